// ---- hw/vmode_pkg.sv ----
/*
  Package for the virtual-mode entry checker: register map, field positions, reset values,
  output module types, check item codes and timing figures.
  Assumes a 32-bit classic Wishbone register bus with byte addressing.
*/
package vmode_pkg;

  // axis count covered by the per-axis status flags
  localparam int AXIS_COUNT = 32;
  localparam int AXIS_IDX_W = 5;

  // clock rate and the length of one operation step
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int CHECK_STEP_NS = 20;
  localparam int CHECK_STEP_CYCLES = (CHECK_STEP_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERR_INFO0 = 8'h08;
  localparam logic [7:0] REG_ERR_INFO1 = 8'h0C;
  localparam logic [7:0] REG_ERR_INFO2 = 8'h10;
  localparam logic [7:0] REG_AXIS_SEL = 8'h14;
  localparam logic [7:0] REG_AXIS_CFG = 8'h18;
  localparam logic [7:0] REG_AXIS_STROKE = 8'h1C;
  localparam logic [7:0] REG_AXIS_STROKE_DEV = 8'h20;

  // control register fields
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_MAP_OK_BIT = 2;
  localparam int CTRL_CAM_MOD_BIT = 3;
  localparam int CTRL_CAM_REG_BIT = 4;
  localparam int CTRL_VER_LSB = 8;
  localparam int CTRL_VER_MSB = 15;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // status register fields
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // per-axis configuration word fields
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_TYPE_MSB = 1;
  localparam int CFG_REAL_BIT = 2;
  localparam int CFG_USED_BIT = 3;
  localparam int CFG_FUNITS_LSB = 4;
  localparam int CFG_FUNITS_MSB = 5;
  localparam int CFG_MUNITS_LSB = 6;
  localparam int CFG_MUNITS_MSB = 7;
  localparam int CFG_CAMNO_BIT = 8;
  localparam int CFG_W = 9;
  localparam logic [8:0] CFG_RESET = 9'h000;

  // version code from which real-mode axes leave the checks (letter H)
  localparam logic [7:0] VER_REAL_EXCLUDE = 8'h48;

  // output module types
  localparam logic [1:0] MOD_ROLLER = 2'h0;
  localparam logic [1:0] MOD_BALL_SCREW = 2'h1;
  localparam logic [1:0] MOD_ROTARY_TABLE = 2'h2;
  localparam logic [1:0] MOD_CAM = 2'h3;

  // error codes stored in the first error information word
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_READY = 16'h0001;
  localparam logic [15:0] ERR_NOT_STOPPED = 16'h0002;
  localparam logic [15:0] ERR_CAM_CHANGED = 16'h0003;
  localparam logic [15:0] ERR_NO_PROGRAM = 16'h0010;
  localparam logic [15:0] ERR_AXIS_MAP = 16'h0004;
  localparam logic [15:0] ERR_SERVO_OFF = 16'h0005;
  localparam logic [15:0] ERR_RESTARTING = 16'h0006;
  localparam logic [15:0] ERR_ENCODER = 16'h0007;
  localparam logic [15:0] ERR_FORCED_STOP = 16'h0008;
  localparam logic [15:0] ERR_SERVO_FAULT = 16'h0009;
  localparam logic [15:0] ERR_HOMING = 16'h000A;
  localparam logic [15:0] ERR_UNITS = 16'h000B;
  localparam logic [15:0] ERR_NO_CAM_DATA = 16'h000C;
  localparam logic [15:0] ERR_NO_CAM_NO = 16'h000D;
  localparam logic [15:0] ERR_STROKE_RANGE = 16'h000E;
  localparam logic [15:0] ERR_STROKE_ODD = 16'h000F;

  // axis field value for an error that belongs to no single axis
  localparam logic [15:0] AXIS_NONE = 16'hFFFF;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_CHECK
  } check_state_type;

endpackage : vmode_pkg

// ---- hw/vmode_entry_checker.sv ----
/*
  Real-to-virtual mode entry checker with a classic Wishbone register slave.
  Assumes all status inputs are synchronous to sys_clk and that software fills the per-axis
  configuration table before raising the mode request.
*/
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module vmode_entry_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic host_ready_flag,
  input wire logic motion_proc_ready_done,
  input wire logic [31:0] axis_start_accepted,
  input wire logic all_axes_servo_on_cmd,
  input wire logic [31:0] axis_servo_restart_busy,
  input wire logic encoder_ok,
  input wire logic forced_stop,
  input wire logic [31:0] axis_servo_fault_flag,
  input wire logic [31:0] axis_homing_request_flag,
  output logic mode_state_flag,
  output logic switch_error_flag
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // helpers

  // lowest set bit index of a 32-bit fail vector
  function automatic logic [15:0] first_axis(input logic [31:0] vec);
    logic [15:0] idx;
    idx = vmode_pkg::AXIS_NONE;
    for (int i = vmode_pkg::AXIS_COUNT - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 16'(i);
      end
    end
    return idx;
  endfunction : first_axis

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] din,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] ctrl;
  logic [vmode_pkg::AXIS_IDX_W-1:0] axis_sel;
  logic [vmode_pkg::CFG_W-1:0] axis_cfg [vmode_pkg::AXIS_COUNT];
  logic [31:0] axis_stroke [vmode_pkg::AXIS_COUNT];
  logic [31:0] axis_stroke_dev [vmode_pkg::AXIS_COUNT];
  logic [15:0] err_code;
  logic [15:0] err_axis;
  logic [1:0] err_type;
  logic req_prev;
  logic [7:0] wait_cnt;
  vmode_pkg::check_state_type state;

  logic wb_req;
  logic wr_en;
  logic [31:0] rd_word;
  logic [31:0] ctrl_merged;
  logic [31:0] cfg_merged;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = wb_req && wb_we_i;

  // write data merged lane by lane into the current contents, cut to width where stored
  assign ctrl_merged = lane_merge({16'h0000, ctrl}, wb_dat_i, wb_sel_i);
  assign cfg_merged = lane_merge(32'(axis_cfg[axis_sel]), wb_dat_i, wb_sel_i);

  // one wait state: ack follows the request by one edge, then drops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // control register, byte lanes 0 and 1
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= vmode_pkg::CTRL_RESET;
    end else if (wr_en && wb_adr_i == vmode_pkg::REG_CTRL) begin
      ctrl <= ctrl_merged[15:0];
    end
  end

  // axis table index
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      axis_sel <= '0;
    end else if (wr_en && wb_adr_i == vmode_pkg::REG_AXIS_SEL && wb_sel_i[0]) begin
      axis_sel <= wb_dat_i[vmode_pkg::AXIS_IDX_W-1:0];
    end
  end

  // per-axis configuration table, written at the selected axis
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < vmode_pkg::AXIS_COUNT; i++) begin
        axis_cfg[i] <= vmode_pkg::CFG_RESET;
        axis_stroke[i] <= 32'h00000000;
        axis_stroke_dev[i] <= 32'h00000000;
      end
    end else if (wr_en) begin
      if (wb_adr_i == vmode_pkg::REG_AXIS_CFG) begin
        axis_cfg[axis_sel] <= cfg_merged[vmode_pkg::CFG_W-1:0];
      end else if (wb_adr_i == vmode_pkg::REG_AXIS_STROKE) begin
        axis_stroke[axis_sel] <= lane_merge(axis_stroke[axis_sel], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == vmode_pkg::REG_AXIS_STROKE_DEV) begin
        axis_stroke_dev[axis_sel] <= lane_merge(axis_stroke_dev[axis_sel], wb_dat_i, wb_sel_i);
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h00000000;
    if (wb_adr_i == vmode_pkg::REG_CTRL) begin
      rd_word = {16'h0000, ctrl};
    end else if (wb_adr_i == vmode_pkg::REG_STATUS) begin
      rd_word[vmode_pkg::STAT_MODE_BIT] = mode_state_flag;
      rd_word[vmode_pkg::STAT_ERR_BIT] = switch_error_flag;
      rd_word[vmode_pkg::STAT_BUSY_BIT] = (state != vmode_pkg::ST_IDLE);
    end else if (wb_adr_i == vmode_pkg::REG_ERR_INFO0) begin
      rd_word = {16'h0000, err_code};
    end else if (wb_adr_i == vmode_pkg::REG_ERR_INFO1) begin
      rd_word = {16'h0000, err_axis};
    end else if (wb_adr_i == vmode_pkg::REG_ERR_INFO2) begin
      rd_word = {30'h00000000, err_type};
    end else if (wb_adr_i == vmode_pkg::REG_AXIS_SEL) begin
      rd_word = 32'(axis_sel);
    end else if (wb_adr_i == vmode_pkg::REG_AXIS_CFG) begin
      rd_word = 32'(axis_cfg[axis_sel]);
    end else if (wb_adr_i == vmode_pkg::REG_AXIS_STROKE) begin
      rd_word = axis_stroke[axis_sel];
    end else if (wb_adr_i == vmode_pkg::REG_AXIS_STROKE_DEV) begin
      rd_word = axis_stroke_dev[axis_sel];
    end
  end

  // read data register, loaded with the request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // check item evaluation

  logic mode_req;
  logic ver_new;
  logic [31:0] is_cam;
  logic [31:0] is_roller;
  logic [31:0] in_scope;
  logic [31:0] no_real;
  logic [31:0] fail_stop;
  logic [31:0] fail_restart;
  logic [31:0] fail_fault;
  logic [31:0] fail_homing;
  logic [31:0] fail_units;
  logic [31:0] fail_camno;
  logic [31:0] fail_stroke;
  logic [31:0] fail_odd;
  logic [15:0] next_code;
  logic [15:0] next_axis;

  assign mode_req = ctrl[vmode_pkg::CTRL_REQ_BIT];
  assign ver_new = ctrl[vmode_pkg::CTRL_VER_MSB:vmode_pkg::CTRL_VER_LSB] >= vmode_pkg::VER_REAL_EXCLUDE;

  // per-axis classification and fail vectors
  always_comb begin
    for (int i = 0; i < vmode_pkg::AXIS_COUNT; i++) begin
      logic [1:0] mt;
      logic used;
      logic real_ax;
      mt = axis_cfg[i][vmode_pkg::CFG_TYPE_MSB:vmode_pkg::CFG_TYPE_LSB];
      used = axis_cfg[i][vmode_pkg::CFG_USED_BIT];
      real_ax = axis_cfg[i][vmode_pkg::CFG_REAL_BIT];
      is_cam[i] = used && !real_ax && mt == vmode_pkg::MOD_CAM;
      is_roller[i] = used && !real_ax && mt == vmode_pkg::MOD_ROLLER;
      in_scope[i] = !(real_ax && ver_new);
      no_real[i] = used && !real_ax;
      fail_stop[i] = axis_start_accepted[i] && in_scope[i];
      fail_restart[i] = axis_servo_restart_busy[i] && used && in_scope[i];
      fail_fault[i] = axis_servo_fault_flag[i] && in_scope[i];
      fail_homing[i] = axis_homing_request_flag[i] && no_real[i] && !is_roller[i];
      fail_units[i] = no_real[i] && !is_roller[i] && (axis_cfg[i][vmode_pkg::CFG_FUNITS_MSB:vmode_pkg::CFG_FUNITS_LSB]
                      != axis_cfg[i][vmode_pkg::CFG_MUNITS_MSB:vmode_pkg::CFG_MUNITS_LSB]);
      fail_camno[i] = is_cam[i] && !axis_cfg[i][vmode_pkg::CFG_CAMNO_BIT];
      fail_stroke[i] = is_cam[i] && (axis_stroke[i] == 32'h00000000 || axis_stroke[i][31]);
      fail_odd[i] = is_cam[i] && axis_stroke_dev[i][0];
    end
  end

  // first abnormal item in check order (code order, with ERR_NO_PROGRAM fourth)
  always_comb begin
    next_code = vmode_pkg::ERR_NONE;
    next_axis = vmode_pkg::AXIS_NONE;
    if (!(host_ready_flag && motion_proc_ready_done)) begin
      next_code = vmode_pkg::ERR_READY;
    end else if (|fail_stop) begin
      next_code = vmode_pkg::ERR_NOT_STOPPED;
      next_axis = first_axis(fail_stop);
    end else if ((|is_cam) && ctrl[vmode_pkg::CTRL_CAM_MOD_BIT]) begin
      next_code = vmode_pkg::ERR_CAM_CHANGED;
      next_axis = first_axis(is_cam);
    end else if (!ctrl[vmode_pkg::CTRL_PROG_BIT]) begin
      next_code = vmode_pkg::ERR_NO_PROGRAM;
    end else if (!ctrl[vmode_pkg::CTRL_MAP_OK_BIT]) begin
      next_code = vmode_pkg::ERR_AXIS_MAP;
    end else if (!all_axes_servo_on_cmd) begin
      next_code = vmode_pkg::ERR_SERVO_OFF;
    end else if (|fail_restart) begin
      next_code = vmode_pkg::ERR_RESTARTING;
      next_axis = first_axis(fail_restart);
    end else if (!encoder_ok) begin
      next_code = vmode_pkg::ERR_ENCODER;
    end else if (forced_stop) begin
      next_code = vmode_pkg::ERR_FORCED_STOP;
    end else if (|fail_fault) begin
      next_code = vmode_pkg::ERR_SERVO_FAULT;
      next_axis = first_axis(fail_fault);
    end else if (|fail_homing) begin
      next_code = vmode_pkg::ERR_HOMING;
      next_axis = first_axis(fail_homing);
    end else if (|fail_units) begin
      next_code = vmode_pkg::ERR_UNITS;
      next_axis = first_axis(fail_units);
    end else if ((|is_cam) && !ctrl[vmode_pkg::CTRL_CAM_REG_BIT]) begin
      next_code = vmode_pkg::ERR_NO_CAM_DATA;
      next_axis = first_axis(is_cam);
    end else if (|fail_camno) begin
      next_code = vmode_pkg::ERR_NO_CAM_NO;
      next_axis = first_axis(fail_camno);
    end else if (|fail_stroke) begin
      next_code = vmode_pkg::ERR_STROKE_RANGE;
      next_axis = first_axis(fail_stroke);
    end else if (|fail_odd) begin
      next_code = vmode_pkg::ERR_STROKE_ODD;
      next_axis = first_axis(fail_odd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // sequencing

  // request edge detector
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_prev <= 1'b0;
    end else begin
      req_prev <= mode_req;
    end
  end

  // check sequencer: idle, settle one step, evaluate
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= vmode_pkg::ST_IDLE;
      wait_cnt <= 8'h00;
    end else begin
      case (state)
        vmode_pkg::ST_IDLE: begin
          if (mode_req && !req_prev && !mode_state_flag) begin
            state <= vmode_pkg::ST_WAIT;
            wait_cnt <= 8'(vmode_pkg::CHECK_STEP_CYCLES - 1);
          end
        end
        vmode_pkg::ST_WAIT: begin
          if (wait_cnt == 8'h00) begin
            state <= vmode_pkg::ST_CHECK;
          end else begin
            wait_cnt <= wait_cnt - 8'h01;
          end
        end
        vmode_pkg::ST_CHECK: begin
          state <= vmode_pkg::ST_IDLE;
        end
        default: begin
          state <= vmode_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // mode state flag; request removal returns to real mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_state_flag <= 1'b0;
    end else if (state == vmode_pkg::ST_CHECK && next_code == vmode_pkg::ERR_NONE) begin
      mode_state_flag <= 1'b1;
    end else if (!mode_req) begin
      mode_state_flag <= 1'b0;
    end
  end

  // error flag and information; only the flag clears when a new check starts, the information holds until the next error
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      switch_error_flag <= 1'b0;
      err_code <= vmode_pkg::ERR_NONE;
      err_axis <= 16'h0000;
      err_type <= 2'h0;
    end else if (state == vmode_pkg::ST_CHECK && next_code != vmode_pkg::ERR_NONE) begin
      switch_error_flag <= 1'b1;
      err_code <= next_code;
      err_axis <= next_axis;
      err_type <= (next_axis == vmode_pkg::AXIS_NONE) ? 2'h0
                : axis_cfg[next_axis[vmode_pkg::AXIS_IDX_W-1:0]][vmode_pkg::CFG_TYPE_MSB:vmode_pkg::CFG_TYPE_LSB];
    end else if (state == vmode_pkg::ST_IDLE && mode_req && !req_prev && !mode_state_flag) begin
      switch_error_flag <= 1'b0;
    end
  end

endmodule : vmode_entry_checker

`default_nettype wire

// ---- tb/vmode_host_axes.sv ----
/*
  Partner model: host sequence program and servo axes, presenting their status levels.
  Assumes the bench sets the wanted levels; they show at the next clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module vmode_host_axes (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic p_host,
  input wire logic p_proc,
  input wire logic p_son,
  input wire logic p_enc,
  input wire logic p_fs,
  input wire logic [31:0] p_st,
  input wire logic [31:0] p_rb,
  input wire logic [31:0] p_flt,
  input wire logic [31:0] p_hom,
  output logic host_ready_flag,
  output logic motion_proc_ready_done,
  output logic all_axes_servo_on_cmd,
  output logic encoder_ok,
  output logic forced_stop,
  output logic [31:0] axis_start_accepted,
  output logic [31:0] axis_servo_restart_busy,
  output logic [31:0] axis_servo_fault_flag,
  output logic [31:0] axis_homing_request_flag
);
  ////////////////////////////////////////////////////////////////
  // ready and servo-on levels, held once per scan; all off in reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {host_ready_flag, motion_proc_ready_done, all_axes_servo_on_cmd} <= 3'h0;
    end else begin
      {host_ready_flag, motion_proc_ready_done, all_axes_servo_on_cmd} <= {p_host, p_proc, p_son};
    end
  end

  // axis and safety status, changing only after a clock edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {encoder_ok, forced_stop} <= 2'h0;
      {axis_start_accepted, axis_servo_restart_busy, axis_servo_fault_flag, axis_homing_request_flag} <= '0;
    end else begin
      {encoder_ok, forced_stop} <= {p_enc, p_fs};
      {axis_start_accepted, axis_servo_restart_busy, axis_servo_fault_flag, axis_homing_request_flag} <=
        {p_st, p_rb, p_flt, p_hom};
    end
  end
endmodule : vmode_host_axes

`default_nettype wire

// ---- tb/vmode_entry_checker_assertions.sv ----
/*
  Checker: bus handshake and mode entry timing seen at the top ports.
  Assumes one clock domain; bound to the design at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none

module vmode_entry_checker_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic host_ready_flag,
  input wire logic motion_proc_ready_done,
  input wire logic all_axes_servo_on_cmd,
  input wire logic encoder_ok,
  input wire logic forced_stop,
  input wire logic [31:0] axis_start_accepted,
  input wire logic [31:0] axis_servo_fault_flag,
  input wire logic mode_state_flag,
  input wire logic switch_error_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////
  // cycles since the last control write that set or cleared the request
  wire logic wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00;
  logic [3:0] since_set;
  logic [3:0] since_clr;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_set <= 4'hF;
      since_clr <= 4'hF;
    end else begin
      since_set <= (wr_ctrl && wb_dat_i[0]) ? 4'h0 : since_set + {3'h0, since_set != 4'hF};
      since_clr <= (wr_ctrl && !wb_dat_i[0]) ? 4'h0 : since_clr + {3'h0, since_clr != 4'hF};
    end
  end

  ////////////////////////////////////////////////////////////////
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h20 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |->
    wb_dat_o[1:0] == {$past(switch_error_flag), $past(mode_state_flag)}) else $error("status mismatch");
  a_result_cause: assert property ($rose(mode_state_flag) || $rose(switch_error_flag) |->
    since_set >= 4'h1 && since_set <= 4'h4) else $error("result without request");
  a_mode_ready: assert property ($rose(mode_state_flag) |-> $past(host_ready_flag && motion_proc_ready_done
    && all_axes_servo_on_cmd && encoder_ok && !forced_stop && axis_start_accepted == 32'h0
    && axis_servo_fault_flag == 32'h0)) else $error("entry with abnormal status");
  a_mode_clear: assert property ($fell(mode_state_flag) |-> since_clr <= 4'h2)
    else $error("mode dropped without clear");
  a_err_held: assert property ($fell(switch_error_flag) |-> since_set <= 4'h2)
    else $error("error dropped without request");
  a_flags_apart: assert property (!(mode_state_flag && switch_error_flag)) else $error("mode and error");

  c_entry: cover property ($rose(mode_state_flag));
  c_refused: cover property ($rose(switch_error_flag));
  c_status: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04);
endmodule : vmode_entry_checker_assertions

bind vmode_entry_checker vmode_entry_checker_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_ready_flag(host_ready_flag),
  .motion_proc_ready_done(motion_proc_ready_done), .all_axes_servo_on_cmd(all_axes_servo_on_cmd),
  .encoder_ok(encoder_ok), .forced_stop(forced_stop), .axis_start_accepted(axis_start_accepted),
  .axis_servo_fault_flag(axis_servo_fault_flag), .mode_state_flag(mode_state_flag),
  .switch_error_flag(switch_error_flag));

`default_nettype wire

// ---- tb/vmode_entry_checker_bench.sv ----
/*
  Bench: random entry attempts over the register bus, judged by a reference of the checks.
  Assumes the package, design, partner model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module vmode_entry_checker_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic p_host = 1'b0, p_proc = 1'b0, p_son = 1'b0, p_enc = 1'b0, p_fs = 1'b0;
  logic [31:0] p_st = '0, p_rb = '0, p_flt = '0, p_hom = '0;
  wire logic host, proc, son, enc, fs, ack, mode, err;
  wire logic [31:0] st, rb, flt, hom, rdat;
  int miscompares = 0;
  int n_compared = 0;
  logic [15:0] ctrl = 16'h0;
  int cfgw[4] = '{default: 0};
  int strk[4] = '{default: 0};
  int sdev[4] = '{default: 0};
  logic [7:0] vers[4] = '{8'h00, 8'h47, 8'h48, 8'hFF};

  always #10 sys_clk = ~sys_clk;

  vmode_entry_checker dut (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .host_ready_flag(host),
    .motion_proc_ready_done(proc), .axis_start_accepted(st), .all_axes_servo_on_cmd(son),
    .axis_servo_restart_busy(rb), .encoder_ok(enc), .forced_stop(fs), .axis_servo_fault_flag(flt),
    .axis_homing_request_flag(hom), .mode_state_flag(mode), .switch_error_flag(err));

  vmode_host_axes host_side (.sys_clk(sys_clk), .arst_n(arst_n), .p_host(p_host), .p_proc(p_proc), .p_son(p_son),
    .p_enc(p_enc), .p_fs(p_fs), .p_st(p_st), .p_rb(p_rb), .p_flt(p_flt), .p_hom(p_hom), .host_ready_flag(host),
    .motion_proc_ready_done(proc), .all_axes_servo_on_cmd(son), .encoder_ok(enc), .forced_stop(fs),
    .axis_start_accepted(st), .axis_servo_restart_busy(rb), .axis_servo_fault_flag(flt),
    .axis_homing_request_flag(hom));

  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      i++;
    end while (ack !== 1'b1 && i < 16);
    q = rdat;
    if (ack !== 1'b1) begin
      miscompares++;
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  function automatic bit bad();
    return $urandom % 10 == 0;
  endfunction : bad

  // reference: first abnormal item in check order, zero when all normal
  function automatic int model_code();
    bit ex, cam;
    bit act[4], iscam[4];
    int a;
    ex = ctrl[15:8] >= 8'h48;
    cam = 0;
    for (a = 0; a < 4; a++) begin
      act[a] = !cfgw[a][2] && cfgw[a][1:0] != 0;
      iscam[a] = !cfgw[a][2] && cfgw[a][1:0] == 3;
      cam |= iscam[a];
    end
    if (!(p_host && p_proc)) return 1;
    if (p_st != 0) return 2;
    if (cam && ctrl[3]) return 3;
    if (!ctrl[1]) return 16;
    if (!ctrl[2]) return 4;
    if (!p_son) return 5;
    for (a = 0; a < 4; a++) if (p_rb[a] && !(ex && cfgw[a][2])) return 6;
    if (!p_enc) return 7;
    if (p_fs) return 8;
    if (p_flt != 0) return 9;
    for (a = 0; a < 4; a++) if (act[a] && p_hom[a]) return 10;
    for (a = 0; a < 4; a++) if (act[a] && cfgw[a][5:4] != cfgw[a][7:6]) return 11;
    if (cam && !ctrl[4]) return 12;
    for (a = 0; a < 4; a++) if (iscam[a] && !cfgw[a][8]) return 13;
    for (a = 0; a < 4; a++) if (iscam[a] && strk[a] < 1) return 14;
    for (a = 0; a < 4; a++) if (iscam[a] && sdev[a][0]) return 15;
    return 0;
  endfunction : model_code

  // random configuration of one axis, read back
  task automatic cfg_axis(input int k);
    logic [31:0] q;
    int c;
    c = $urandom & 32'h33;
    c[2] = ($urandom % 4) == 0;
    c[3] = 1'b1;
    c[7:6] = bad() ? ~c[5:4] : c[5:4];
    c[8] = !bad();
    cfgw[k] = c;
    strk[k] = bad() ? (($urandom % 2) ? 0 : 32'h80000000 | $urandom) : (($urandom % 2) ? 1 : 32'h7FFFFFFF);
    sdev[k] = ($urandom & 32'hFFFE) | 32'(bad());
    wb(1'b1, 8'h14, 32'(k), q);
    wb(1'b1, 8'h18, c, q);
    wb(1'b1, 8'h1C, strk[k], q);
    wb(1'b1, 8'h20, sdev[k], q);
    wb(1'b0, 8'h18, 32'h0, q);
    `CHK(q, c)
  endtask : cfg_axis

  // one entry attempt with random status, then back to real mode
  task automatic trial();
    logic [31:0] q;
    int e;
    cfg_axis($urandom % 4);
    p_host <= !bad();
    p_proc <= !bad();
    p_son <= !bad();
    p_enc <= !bad();
    p_fs <= bad();
    p_st <= bad() ? $urandom & 32'hFFFFFFF0 : 32'h0;
    p_rb <= bad() ? $urandom : 32'h0;
    p_flt <= bad() ? $urandom & 32'hFFFFFFF0 : 32'h0;
    p_hom <= bad() ? $urandom : 32'h0;
    ctrl = {vers[$urandom % 4], 3'h0, !bad(), bad(), !bad(), !bad(), 1'b0};
    wb(1'b1, 8'h00, {16'h0, ctrl | 16'h0001}, q);
    e = model_code();
    repeat (3) @(posedge sys_clk);
    `CHK({mode, err}, {e == 0, e != 0})
    wb(1'b0, 8'h08, 32'h0, q);
    if (e != 0) `CHK(q[15:0], e[15:0])
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q[2:0], {1'b0, e != 0, e == 0})
    wb(1'b1, 8'h00, {16'h0, ctrl}, q);
    `CHK({mode, err}, {1'b0, e != 0})
  endtask : trial

  ////////////////////////////////////////////////////////////////
  // reset, register checks, then the random entry attempts
  initial begin
    logic [31:0] q;
    int t;
    void'($urandom(32'hA214));
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, 8'h00, 32'h0, q);
    `CHK(q, 32'h0)
    wb(1'b1, 8'h40, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h40, 32'h0, q);
    `CHK(q, 32'h0)
    wb(1'b1, 8'h04, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q, 32'h0)
    for (t = 0; t < 4; t++) cfg_axis(t);
    for (t = 0; t < 80; t++) trial();
    conclude();
  end
endmodule : vmode_entry_checker_bench

`default_nettype wire
